// ==== design/dac_ctl_pkg.sv ====
package dac_ctl_pkg;

    localparam int          DATA_W       = 16;
    localparam int          AXI_AW       = 4;
    // register byte addresses
    localparam logic [3:0]  CTRL_ADDR    = 4'h0;
    localparam logic [3:0]  STATUS_ADDR  = 4'h4;
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY    = 2'b00;
    localparam logic [1:0]  RESP_SLVERR  = 2'b10;
    localparam logic [15:0] MIDSCALE     = 16'h8000;
    localparam int          CTRL_BITS    = 6;
    localparam int          STATUS_BITS  = 6;
    localparam int          RATE_DIV_DEF = 2;

    // control register fields, bit 5 downward
    typedef struct packed {
        logic fourPinSerial;   // bit 5
        logic externalClock;   // bit 4
        logic reverseB;        // bit 3
        logic interleaved;     // bit 2
        logic flagEnable;      // bit 1
        logic syncStrobeSel;   // bit 0
    } ctrl_s;

    // status register fields, bit 5 downward
    typedef struct packed {
        logic outputPending;   // bit 5
        logic channelPhaseB;   // bit 4
        logic serialEnabled;   // bit 3
        logic sleeping;        // bit 2
        logic transmitOn;      // bit 1
        logic pllLocked;       // bit 0
    } status_s;

    typedef struct packed {
        logic              channelFlag;
        logic [DATA_W-1:0] channelAData;
        logic [DATA_W-1:0] channelBData;
    } in_word_s;

endpackage

// ==== design/two_entry_buffer.sv ====
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 33
) (
    // clock and reset
    input  wire logic             core_clk,
    input  wire logic             rst,
    // filling side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // draining side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    logic [WIDTH-1:0] slot_reg [2];
    logic             wrPtr_reg;
    logic             rdPtr_reg;
    logic [1:0]       count_reg;
    logic [1:0]       count_next;
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    initial begin
        if (WIDTH < 1) begin
            $error("two_entry_buffer: WIDTH must be positive");
        end
    end

    assign inReady    = (count_reg != 2'h2);
    assign outValid   = (count_reg != 2'h0);
    assign outData    = slot_reg[rdPtr_reg];
    assign count_next = count_reg + {1'b0, push} - {1'b0, pop};

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wrPtr_reg <= 1'b0;
            rdPtr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            wrPtr_reg <= wrPtr_reg ^ push;
            rdPtr_reg <= rdPtr_reg ^ pop;
            count_reg <= count_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (push) begin
            slot_reg[wrPtr_reg] <= inData;
        end
    end
endmodule

// ==== design/dac_input_control.sv ====
// Summary of operation
// - sync select 0: strobe high clears NCO phase
// - sync select 1 with external clock: strobe edge aligns divider, clears NCO
// - PLL mode: lock output follows PLL lock
// - external clock mode: lock pin shows input-rate clock
// - flag enable 1: channel flag identifies words
// - flagged-high words go to channel B
// - chip reset low holds all logic reset
// - three-pin mode: data pin is bidirectional
// - four-pin mode: data pin input only
// - read pin idle three-pin, drives four-pin
// - serial enable active low, input only
// - sleep high powers down asynchronously
// - transmit gate rise resynchronises A/B alignment
// - after gate rise: A first, then alternate
// - transmit gate low forces midscale outputs
// - B-bus reverse setting reverses B bits when not interleaved
`timescale 1ns/1ps
module dac_input_control
    import dac_ctl_pkg::*;
#(
    parameter int RATE_DIV = dac_ctl_pkg::RATE_DIV_DEF
) (
    // clock and reset
    input  wire logic                       core_clk,
    input  wire logic                       rst,
    input  wire logic                       chip_reset_n,
    // AXI4-Lite register port
    input  wire logic [dac_ctl_pkg::AXI_AW-1:0] s_axi_awaddr,
    input  wire logic                       s_axi_awvalid,
    output logic                            s_axi_awready,
    input  wire logic [31:0]                s_axi_wdata,
    input  wire logic [3:0]                 s_axi_wstrb,
    input  wire logic                       s_axi_wvalid,
    output logic                            s_axi_wready,
    output logic [1:0]                      s_axi_bresp,
    output logic                            s_axi_bvalid,
    input  wire logic                       s_axi_bready,
    input  wire logic [dac_ctl_pkg::AXI_AW-1:0] s_axi_araddr,
    input  wire logic                       s_axi_arvalid,
    output logic                            s_axi_arready,
    output logic [31:0]                     s_axi_rdata,
    output logic [1:0]                      s_axi_rresp,
    output logic                            s_axi_rvalid,
    input  wire logic                       s_axi_rready,
    // input word stream
    input  wire dac_ctl_pkg::in_word_s      inWord,
    input  wire logic                       inValid,
    output logic                            inReady,
    // control pins
    input  wire logic                       phaseStrobe,
    input  wire logic                       transmit_gate,
    input  wire logic                       sleepPin,
    input  wire logic                       serial_enable_n,
    input  wire logic                       pllLockedRaw,
    output logic                            pll_lock_out,
    output logic                            powerDown,
    // core datapath side
    output logic                            ncoPhaseClear,
    output logic [15:0]                     dacAOut,
    output logic [15:0]                     dacBOut,
    output logic                            sampleValid,
    input  wire logic                       sampleReady,
    // serial pins
    input  wire logic                       sdioIn,
    output logic                            sdioOut,
    output logic                            sdioDriveN,
    output logic                            serial_read_out,
    output logic                            sdoDriveN,
    input  wire logic                       serialReadData,
    input  wire logic                       serialReadActive,
    output logic                            serialWriteData,
    output logic                            serialFrameActive
);
    import dac_ctl_pkg::*;

    initial begin
        if (RATE_DIV < 2) begin
            $error("dac_input_control: RATE_DIV must be at least 2");
        end
    end

    // reset: async assert from either source, synchronous release
    logic [1:0] rstSync_reg;
    wire        rawReset = rst || !chip_reset_n;
    wire        coreRst  = !rstSync_reg[1];

    always_ff @(posedge core_clk or posedge rawReset) begin
        if (rawReset) begin
            rstSync_reg <= 2'b00;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end

    // pin synchronisers
    localparam int NSYNC = 6;
    logic [NSYNC-1:0] pinMeta_reg;
    logic [NSYNC-1:0] pinSync_reg;
    logic             strobePrev_reg;
    logic             gatePrev_reg;
    wire  [NSYNC-1:0] pinRaw = {sdioIn, pllLockedRaw, serial_enable_n, sleepPin,
                                transmit_gate, phaseStrobe};
    wire              strobeSync = pinSync_reg[0];
    wire              gateSync   = pinSync_reg[1];
    wire              sleepSync  = pinSync_reg[2];
    wire              serEnNSync = pinSync_reg[3];
    wire              lockSync   = pinSync_reg[4];
    wire              sdioSync   = pinSync_reg[5];
    wire              strobeRise = strobeSync && !strobePrev_reg;
    wire              gateRise   = gateSync && !gatePrev_reg;

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            pinMeta_reg    <= '0;
            pinSync_reg    <= '0;
            strobePrev_reg <= 1'b0;
            gatePrev_reg   <= 1'b0;
        end else begin
            pinMeta_reg    <= pinRaw;
            pinSync_reg    <= pinMeta_reg;
            strobePrev_reg <= strobeSync;
            gatePrev_reg   <= gateSync;
        end
    end

    assign powerDown = sleepPin;

    // register slave
    ctrl_s  ctrl_reg;
    logic   awHeld_reg;
    logic   wHeld_reg;
    logic [AXI_AW-1:0] awAddr_reg;
    logic [31:0]       wData_reg;
    logic [3:0]        wStrb_reg;
    logic   bValid_reg;
    logic [1:0] bResp_reg;
    logic   rValid_reg;
    logic [1:0] rResp_reg;
    logic [31:0] rData_reg;
    status_s statusWord;

    wire awTake   = s_axi_awvalid && s_axi_awready;
    wire wTake    = s_axi_wvalid && s_axi_wready;
    wire haveAw   = awHeld_reg || awTake;
    wire haveW    = wHeld_reg || wTake;
    wire [AXI_AW-1:0] wrAddr = awHeld_reg ? awAddr_reg : s_axi_awaddr;
    wire [31:0]       wrData = wHeld_reg ? wData_reg : s_axi_wdata;
    wire [3:0]        wrStrb = wHeld_reg ? wStrb_reg : s_axi_wstrb;
    wire doWrite  = haveAw && haveW && !bValid_reg;
    wire wrCtrl   = doWrite && (wrAddr == CTRL_ADDR);
    wire wrKnown  = wrCtrl || (wrAddr == STATUS_ADDR);
    wire arTake   = s_axi_arvalid && s_axi_arready;
    wire [31:0] rdWord = (s_axi_araddr == CTRL_ADDR)   ? {{(32-CTRL_BITS){1'b0}}, ctrl_reg} :
                         (s_axi_araddr == STATUS_ADDR) ? {{(32-STATUS_BITS){1'b0}}, statusWord} :
                         32'h0000_0000;
    wire rdKnown  = (s_axi_araddr == CTRL_ADDR) || (s_axi_araddr == STATUS_ADDR);

    assign s_axi_awready = !awHeld_reg && !bValid_reg;
    assign s_axi_wready  = !wHeld_reg && !bValid_reg;
    assign s_axi_bvalid  = bValid_reg;
    assign s_axi_bresp   = bResp_reg;
    assign s_axi_arready = !rValid_reg;
    assign s_axi_rvalid  = rValid_reg;
    assign s_axi_rresp   = rResp_reg;
    assign s_axi_rdata   = rData_reg;

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            awHeld_reg <= 1'b0;
            wHeld_reg  <= 1'b0;
            awAddr_reg <= '0;
            wData_reg  <= 32'h0000_0000;
            wStrb_reg  <= 4'h0;
            bValid_reg <= 1'b0;
            bResp_reg  <= RESP_OKAY;
        end else begin
            if (awTake) begin
                awAddr_reg <= s_axi_awaddr;
            end
            if (wTake) begin
                wData_reg <= s_axi_wdata;
                wStrb_reg <= s_axi_wstrb;
            end
            awHeld_reg <= haveAw && !doWrite;
            wHeld_reg  <= haveW && !doWrite;
            if (doWrite) begin
                bValid_reg <= 1'b1;
                bResp_reg  <= wrKnown ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bValid_reg <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            ctrl_reg <= ctrl_s'(CTRL_RESET[CTRL_BITS-1:0]);
        end else if (wrCtrl && wrStrb[0]) begin
            ctrl_reg <= ctrl_s'(wrData[CTRL_BITS-1:0]);
        end
    end

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            rValid_reg <= 1'b0;
            rResp_reg  <= RESP_OKAY;
            rData_reg  <= 32'h0000_0000;
        end else if (arTake) begin
            rValid_reg <= 1'b1;
            rResp_reg  <= rdKnown ? RESP_OKAY : RESP_SLVERR;
            rData_reg  <= rdWord;
        end else if (s_axi_rready) begin
            rValid_reg <= 1'b0;
        end
    end

    // NCO clear and divided-clock alignment
    localparam int RCW = $clog2(RATE_DIV);
    logic [RCW-1:0] rateCnt_reg;
    logic           rateClk_reg;
    wire            rateLast  = (rateCnt_reg == RCW'(RATE_DIV - 1));
    wire            alignRate = ctrl_reg.syncStrobeSel && ctrl_reg.externalClock && strobeRise;

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            rateCnt_reg   <= '0;
            rateClk_reg   <= 1'b0;
            ncoPhaseClear <= 1'b0;
            pll_lock_out  <= 1'b0;
        end else begin
            ncoPhaseClear <= strobeSync;
            if (alignRate) begin
                rateCnt_reg <= '0;
                rateClk_reg <= 1'b0;
            end else if (rateLast) begin
                rateCnt_reg <= '0;
                rateClk_reg <= !rateClk_reg;
            end else begin
                rateCnt_reg <= rateCnt_reg + 1'b1;
            end
            pll_lock_out <= ctrl_reg.externalClock ? rateClk_reg : lockSync;
        end
    end

    // word path: buffer, then channel steering
    in_word_s bufWord;
    logic     bufValid;
    logic     phaseB_reg;
    logic [15:0] aHold_reg;
    logic     sampleValid_reg;
    wire      drainReady = !sampleValid_reg || sampleReady;
    wire      takeWord   = bufValid && drainReady && !gateRise;
    wire [15:0] bReversed = {<<{bufWord.channelBData}};
    wire [15:0] bLane     = ctrl_reg.reverseB ? bReversed : bufWord.channelBData;
    wire      wordIsB    = ctrl_reg.flagEnable ? bufWord.channelFlag : phaseB_reg;
    wire      pairDone   = !ctrl_reg.interleaved || wordIsB;

    two_entry_buffer #(
        .WIDTH ($bits(in_word_s))
    ) u_buffer (
        .core_clk (core_clk),
        .rst      (coreRst),
        .inValid  (inValid),
        .inReady  (inReady),
        .inData   (inWord),
        .outValid (bufValid),
        .outReady (takeWord),
        .outData  (bufWord)
    );

    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            phaseB_reg      <= 1'b0;
            aHold_reg       <= MIDSCALE;
            sampleValid_reg <= 1'b0;
            dacAOut         <= MIDSCALE;
            dacBOut         <= MIDSCALE;
        end else begin
            if (gateRise) begin
                phaseB_reg <= 1'b0;
            end else if (takeWord && ctrl_reg.interleaved) begin
                phaseB_reg <= !wordIsB;
            end
            if (takeWord && ctrl_reg.interleaved && !wordIsB) begin
                aHold_reg <= bufWord.channelAData;
            end
            if (takeWord && pairDone) begin
                sampleValid_reg <= 1'b1;
                dacAOut <= ctrl_reg.interleaved ? aHold_reg : bufWord.channelAData;
                dacBOut <= ctrl_reg.interleaved ? bufWord.channelAData : bLane;
            end else if (sampleReady) begin
                sampleValid_reg <= 1'b0;
            end
            if (!gateSync) begin
                dacAOut <= MIDSCALE;
                dacBOut <= MIDSCALE;
            end
        end
    end

    assign sampleValid = sampleValid_reg;

    // serial pin direction
    always_ff @(posedge core_clk or posedge coreRst) begin
        if (coreRst) begin
            sdioOut           <= 1'b0;
            sdioDriveN        <= 1'b1;
            serial_read_out   <= 1'b0;
            sdoDriveN         <= 1'b1;
            serialWriteData   <= 1'b0;
            serialFrameActive <= 1'b0;
        end else begin
            serialFrameActive <= !serEnNSync;
            serialWriteData   <= sdioSync;
            sdioOut           <= serialReadData;
            sdioDriveN        <= ctrl_reg.fourPinSerial || !serialReadActive;
            serial_read_out   <= serialReadData;
            sdoDriveN         <= !ctrl_reg.fourPinSerial;
        end
    end

    assign statusWord = '{outputPending: sampleValid_reg, channelPhaseB: phaseB_reg,
                          serialEnabled: !serEnNSync, sleeping: sleepSync,
                          transmitOn: gateSync, pllLocked: lockSync};

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (coreRst);

    sequence s_strobeRiseAligned;
        strobeRise && ctrl_reg.syncStrobeSel && ctrl_reg.externalClock;
    endsequence

    property p_ncoClear;
        strobeSync |=> ncoPhaseClear;
    endproperty
    a_ncoClear: assert property (p_ncoClear) else $error("nco clear missed");

    property p_align;
        s_strobeRiseAligned |=> (rateCnt_reg == '0) ##1 !rateClk_reg || rateLast;
    endproperty
    a_align: assert property (p_align) else $error("divider not aligned");

    property p_lockPll;
        (!ctrl_reg.externalClock && lockSync) ##1 !ctrl_reg.externalClock |-> pll_lock_out;
    endproperty
    a_lockPll: assert property (p_lockPll) else $error("lock output wrong");

    property p_lockExt;
        (ctrl_reg.externalClock && rateLast && !alignRate) ##1 ctrl_reg.externalClock
            |=> pll_lock_out != $past(pll_lock_out);
    endproperty
    a_lockExt: assert property (p_lockExt) else $error("rate clock not on lock pin");

    property p_flagB;
        (takeWord && ctrl_reg.interleaved && ctrl_reg.flagEnable && bufWord.channelFlag
            && gateSync) |=> dacBOut == $past(bufWord.channelAData);
    endproperty
    a_flagB: assert property (p_flagB) else $error("flagged word not on B");

    property p_resync;
        gateRise |=> !phaseB_reg;
    endproperty
    a_resync: assert property (p_resync) else $error("gate rise left phase B");

    property p_alternate;
        (takeWord && ctrl_reg.interleaved && !ctrl_reg.flagEnable)
            |=> phaseB_reg != $past(phaseB_reg);
    endproperty
    a_alternate: assert property (p_alternate) else $error("no alternation");

    property p_midscale;
        !gateSync |=> dacAOut == MIDSCALE && dacBOut == MIDSCALE;
    endproperty
    a_midscale: assert property (p_midscale) else $error("output not midscale");

    property p_sdioIn;
        ctrl_reg.fourPinSerial ##1 ctrl_reg.fourPinSerial |-> sdioDriveN;
    endproperty
    a_sdioIn: assert property (p_sdioIn) else $error("data pin driven in four-pin");

    property p_sdo;
        !ctrl_reg.fourPinSerial ##1 !ctrl_reg.fourPinSerial |-> sdoDriveN;
    endproperty
    a_sdo: assert property (p_sdo) else $error("read pin driven in three-pin");
endmodule

// ==== testbench/baseband_model.sv ====
`timescale 1ns/1ps
module baseband_model (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // word stream toward the block
    output dac_ctl_pkg::in_word_s      inWord,
    output logic                       inValid,
    input  wire logic                  inReady
);
    import dac_ctl_pkg::*;

    in_word_s q[$];

    // word held until taken; idle bus shows a changing pattern
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            inValid <= 1'b0;
            inWord <= '0;
        end else if (!inValid || inReady) begin
            if (q.size() != 0) begin
                inWord <= q.pop_front();
                inValid <= 1'b1;
            end else begin
                inValid <= 1'b0;
                inWord <= ~inWord;
            end
        end
    end
endmodule

// ==== testbench/dac_input_control_bench.sv ====
`timescale 1ns/1ps
module dac_input_control_bench;
    import dac_ctl_pkg::*;
    localparam int RDIV = 2;
    logic       core_clk, rst, chip_reset_n, awvalid, awready, wvalid, wready, bvalid, bready;
    logic       arvalid, arready, rvalid, rready, inValid, inReady, phaseStrobe, transmit_gate;
    logic       sleepPin, serial_enable_n, pllLockedRaw, pll_lock_out, powerDown, ncoPhaseClear;
    logic       sampleValid, sampleReady, sdioIn, sdioOut, sdioDriveN, serial_read_out, sdoDriveN;
    logic       serialReadData, serialReadActive, serialWriteData, serialFrameActive;
    logic [3:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [15:0] dacAOut, dacBOut;
    in_word_s   inWord;
    int         err_count, samples_checked, cycles;

    dac_input_control #(.RATE_DIV(RDIV)) u_dut (.core_clk(core_clk), .rst(rst),
        .chip_reset_n(chip_reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .inWord(inWord), .inValid(inValid), .inReady(inReady), .phaseStrobe(phaseStrobe),
        .transmit_gate(transmit_gate), .sleepPin(sleepPin), .serial_enable_n(serial_enable_n),
        .pllLockedRaw(pllLockedRaw), .pll_lock_out(pll_lock_out), .powerDown(powerDown),
        .ncoPhaseClear(ncoPhaseClear), .dacAOut(dacAOut), .dacBOut(dacBOut),
        .sampleValid(sampleValid), .sampleReady(sampleReady), .sdioIn(sdioIn),
        .sdioOut(sdioOut), .sdioDriveN(sdioDriveN), .serial_read_out(serial_read_out),
        .sdoDriveN(sdoDriveN), .serialReadData(serialReadData),
        .serialReadActive(serialReadActive), .serialWriteData(serialWriteData),
        .serialFrameActive(serialFrameActive));

    baseband_model u_src (.core_clk(core_clk), .rst(rst), .inWord(inWord),
        .inValid(inValid), .inReady(inReady));

    initial begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 6000) begin
            err_count++;
            finish_test();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    task automatic axiWrite(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
        bit awDone, wDone;
        awDone = 0;
        wDone = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(awDone && wDone)) begin
            @(posedge core_clk);
            if (!awDone && awready) begin
                awDone = 1;
                awvalid <= 1'b0;
            end
            if (!wDone && wready) begin
                wDone = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge core_clk); while (bvalid !== 1'b1);
        bready <= 1'b0;
        check(bresp, er);
    endtask

    task automatic axiRead(input logic [3:0] a, output logic [31:0] d, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge core_clk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge core_clk); while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        check(rresp, er);
    endtask

    function automatic in_word_s mk(logic f, logic [15:0] a, logic [15:0] b);
        return '{f, a, b};
    endfunction

    function automatic logic [15:0] rev16(logic [15:0] v);
        for (int i = 0; i < 16; i++)
            rev16[i] = v[15-i];
    endfunction

    task automatic takeSample(input logic [15:0] ea, input logic [15:0] eb);
        sampleReady <= 1'b1;
        do @(posedge core_clk); while (sampleValid !== 1'b1);
        check(dacAOut, ea);
        check(dacBOut, eb);
    endtask

    task automatic gatePulse();
        transmit_gate <= 1'b0;
        cyc(5);
        check(dacAOut, MIDSCALE);
        check(dacBOut, MIDSCALE);
        transmit_gate <= 1'b1;
        cyc(5);
    endtask

    task automatic testRegs();
        logic [31:0] d;
        axiRead(CTRL_ADDR, d, RESP_OKAY);
        check(d, CTRL_RESET);
        axiWrite(4'hc, 32'h3f, RESP_SLVERR);
        axiRead(4'h8, d, RESP_SLVERR);
        axiRead(CTRL_ADDR, d, RESP_OKAY);
        check(d, CTRL_RESET);
        $display("end of test: registers");
    endtask

    task automatic testPlain();
        axiWrite(CTRL_ADDR, 32'h08, RESP_OKAY);
        transmit_gate <= 1'b1;
        sampleReady <= 1'b0;
        cyc(5);
        for (int k = 0; k < 4; k++)
            u_src.q.push_back(mk(1'b0, 16'h1111 * (k + 1), 16'h000f >> (3 - k)));
        cyc(15);
        check(inReady, 1'b0);
        for (int k = 0; k < 4; k++)
            takeSample(16'h1111 * (k + 1), rev16(16'h000f >> (3 - k)));
        $display("end of test: plain stream");
    endtask

    task automatic testInterleave();
        axiWrite(CTRL_ADDR, 32'h04, RESP_OKAY);
        gatePulse();
        u_src.q = '{mk(0, 16'h0a0a, 0), mk(0, 16'h0b0b, 0), mk(0, 16'h0c0c, 0)};
        takeSample(16'h0a0a, 16'h0b0b);
        cyc(10);
        gatePulse();
        u_src.q = '{mk(0, 16'h1111, 0), mk(0, 16'h2222, 0)};
        takeSample(16'h1111, 16'h2222);
        axiWrite(CTRL_ADDR, 32'h06, RESP_OKAY);
        gatePulse();
        u_src.q = '{mk(0, 16'h3030, 0), mk(0, 16'h4040, 0), mk(1, 16'h5050, 0)};
        takeSample(16'h4040, 16'h5050);
        $display("end of test: interleave");
    endtask

    task automatic testPins();
        for (int s = 0; s < 2; s++) begin
            axiWrite(CTRL_ADDR, 32'h10 | s, RESP_OKAY);
            phaseStrobe <= 1'b1;
            cyc(5);
            check(ncoPhaseClear, 1'b1);
            phaseStrobe <= 1'b0;
            cyc(5);
            check(ncoPhaseClear, 1'b0);
        end
        $display("end of test: strobe");
    endtask

    task automatic testLock();
        int r;
        logic p;
        r = 0;
        axiWrite(CTRL_ADDR, 32'h00, RESP_OKAY);
        pllLockedRaw <= 1'b1;
        cyc(6);
        check(pll_lock_out, 1'b1);
        pllLockedRaw <= 1'b0;
        cyc(6);
        check(pll_lock_out, 1'b0);
        axiWrite(CTRL_ADDR, 32'h10, RESP_OKAY);
        cyc(6);
        p = pll_lock_out;
        repeat (8 * RDIV) begin
            @(posedge core_clk);
            if (pll_lock_out === 1'b1 && p === 1'b0)
                r++;
            p = pll_lock_out;
        end
        check(r, 4);
        $display("end of test: lock pin");
    endtask

    task automatic testSerial();
        axiWrite(CTRL_ADDR, 32'h00, RESP_OKAY);
        serialReadActive <= 1'b1;
        serialReadData <= 1'b1;
        serial_enable_n <= 1'b0;
        sdioIn <= 1'b1;
        cyc(5);
        check(sdioDriveN, 1'b0);
        check(sdioOut, 1'b1);
        check(serialWriteData, 1'b1);
        check(sdoDriveN, 1'b1);
        check(serialFrameActive, 1'b1);
        serialReadActive <= 1'b0;
        cyc(3);
        check(sdioDriveN, 1'b1);
        axiWrite(CTRL_ADDR, 32'h20, RESP_OKAY);
        serialReadActive <= 1'b1;
        serialReadData <= 1'b0;
        cyc(5);
        check(sdioDriveN, 1'b1);
        check(sdoDriveN, 1'b0);
        check(serial_read_out, 1'b0);
        serial_enable_n <= 1'b1;
        cyc(5);
        check(serialFrameActive, 1'b0);
        $display("end of test: serial pins");
    endtask

    task automatic testSleepReset();
        logic [31:0] d;
        @(posedge core_clk);
        sleepPin <= 1'b1;
        #3 check(powerDown, 1'b1);
        @(posedge core_clk);
        sleepPin <= 1'b0;
        #3 check(powerDown, 1'b0);
        @(posedge core_clk);
        chip_reset_n <= 1'b0;
        cyc(2);
        check(sdoDriveN, 1'b1);
        check(dacAOut, MIDSCALE);
        chip_reset_n <= 1'b1;
        cyc(3);
        axiRead(CTRL_ADDR, d, RESP_OKAY);
        check(d, CTRL_RESET);
        axiRead(STATUS_ADDR, d, RESP_OKAY);
        check(d, 32'h0000_0002);
        $display("end of test: sleep and chip reset");
    endtask

    initial begin
        {rst, awvalid, wvalid, bready, arvalid, rready, phaseStrobe, transmit_gate} = 8'hff;
        {awvalid, wvalid, bready, arvalid, rready, phaseStrobe, transmit_gate} = '0;
        {sleepPin, pllLockedRaw, sampleReady, sdioIn, serialReadData, serialReadActive} = '0;
        chip_reset_n = 1'b1;
        serial_enable_n = 1'b1;
        {awaddr, araddr, wdata} = '0;
        {err_count, samples_checked, cycles} = '0;
        cyc(6);
        rst <= 1'b0;
        cyc(3);
        testRegs();
        testPlain();
        testInterleave();
        testPins();
        testLock();
        testSerial();
        testSleepReset();
        finish_test();
    end
endmodule
